// File: hdl/tlg_cfg.svh
// tlg_cfg.svh: constants of the lamp and brake gating block
// assumes a 10 MHz system clock and byte addresses on the register bus
`ifndef TLG_CFG_SVH
`define TLG_CFG_SVH
// ****************************************
// timing
// ****************************************
`define TLG_CLK_KHZ 10000
`define TLG_TICK_MS 50
`define TLG_TICK_CYC (`TLG_TICK_MS * `TLG_CLK_KHZ)
`define TLG_POWERUP_MS 2500
`define TLG_RAPID_HALF_MS 200
`define TLG_SLOW_HALF_MS 1250
`define TLG_DB_TIMEOUT_MS 180000
`define TLG_DB_COOL_MS 120000
`define TLG_MS2TICKS(ms) ((ms) / `TLG_TICK_MS)
// ****************************************
// thresholds and slip targets
// ****************************************
`define TLG_DB_MAX_MPH 8'h19
`define TLG_OFFROAD_MPH 8'h19
`define TLG_SLIP_BASE 8'h10
`define TLG_SLIP_HIGH 8'h20
`define TLG_SLIP_LOW 8'h08
// ****************************************
// registers
// ****************************************
`define TLG_REG_CTRL 4'h0
`define TLG_REG_PEDAL 4'h4
`define TLG_REG_STATUS 4'h8
`define TLG_CTRL_TOOL 0
`define TLG_CTRL_DYNO 1
`define TLG_CTRL_MUD 2
`define TLG_CTRL_TRAILER 3
`define TLG_CTRL_RST 4'h8
`define TLG_PEDAL_RST 8'h80
`define TLG_ST_BRAKE 0
`define TLG_ST_TIMEOUT 1
`define TLG_ST_MUD 2
`define TLG_ST_DB 3
`define TLG_ST_SELFTEST 4
`define TLG_ST_DISABLED 5
// ****************************************
// wheel corners
// ****************************************
`define TLG_W_FL 0
`define TLG_W_FR 1
`define TLG_W_RL 2
`define TLG_W_RR 3
`endif

// File: hdl/tlg_pkg.sv
// tlg_pkg.sv: types of the lamp and brake gating block
// assumes tlg_cfg.svh for all numeric constants
`default_nettype none
package tlg_pkg;
  typedef logic [7:0] tlg_byte_t;
  typedef logic [3:0] tlg_corner_t;
  typedef enum logic [1:0] {
    MUD_OFF = 2'b00,
    MUD_HELD = 2'b01,
    MUD_ON = 2'b11,
    MUD_EXIT = 2'b10
  } tlg_mud_t;
endpackage
`default_nettype wire

// File: hdl/tlg_ticker.sv
// tlg_ticker.sv: saturating tick counter with clear
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/1ns
`default_nettype none
module tlg_ticker #(
  parameter int W = 12
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic tick,
  input wire logic clr,
  input wire logic run,
  output logic [W-1:0] count
);
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (run && tick && count != '1) begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/tlg_gating.sv
// tlg_gating.sv: traction lamp, differential braking and engine gating
// assumes same-clock inputs from wheel, network and fault logic;
// the mud/snow switch is an asynchronous pin
//
// How it works
// - lamp on about 2.5 s at power-up, then off unless faults present
// - lamp steady on while traction or stability is disabled and no intervention or mud/snow flash is due
// - lamp flashes 2.5 times per second during an intervention
// - lamp flashes once every 2.5 s while mud/snow mode engaged
// - antiskid off-road mode disables stability below 25 mph, lamp steady
// - one-side spin applies light brake to the spinning side
// - differential braking only at or below 25 mph
// - no differential braking, torque or adaptive slip until first service brake seen
// - parked message inhibits differential braking and engine control
// - dynamometer test mode inhibits differential braking and engine control
// - tool request over serial link inhibits differential braking and engine control
// - 3 minutes continuous braking times out, then 2 minutes cool-off
// - FAULT_INHIBIT inhibits braking, engine control and adaptive slip; FAULT_ANY only lights the lamp
// - engine torque limiting requested at every speed
// - pedal above threshold raises the slip target
// - cornering lowers the slip target
// - mud/snow entered by switch or network, left by press and release
// - rollover overrides throttle, brakes all wheels scaled by roll risk
// - slide cuts throttle first, then brakes corners and maybe trailer
// - over-steer brakes outside front, under-steer inside rear
// - driveline drag slip requests more engine torque
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "tlg_cfg.svh"
module tlg_gating #(
  parameter int TICK_CYCLES = `TLG_TICK_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic MUD_SW,
  input wire logic NET_MUD_REQ,
  input wire tlg_pkg::tlg_byte_t SPEED_MPH,
  input wire logic SPIN_LEFT,
  input wire logic SPIN_RIGHT,
  input wire logic SVC_BRAKE,
  input wire logic PARK_MSG,
  input wire logic FAULT_ANY,
  input wire logic FAULT_INHIBIT,
  input wire logic STAB_OFF,
  input wire logic SKID_OFFROAD,
  input wire logic TRAC_EVENT,
  input wire tlg_pkg::tlg_byte_t PEDAL_POS,
  input wire logic CORNERING,
  input wire logic ROLL_EVENT,
  input wire tlg_pkg::tlg_byte_t ROLL_RISK,
  input wire logic YAW_OVERSTEER,
  input wire logic YAW_UNDERSTEER,
  input wire logic TURN_LEFT,
  input wire logic DRAG_SLIP,
  output logic LAMP,
  output logic DB_BRAKE_L,
  output logic DB_BRAKE_R,
  output logic ETL_REQ,
  output logic TORQUE_UP_REQ,
  output tlg_pkg::tlg_byte_t SLIP_TARGET,
  output logic THROTTLE_CUT,
  output tlg_pkg::tlg_corner_t WHEEL_BRAKE,
  output tlg_pkg::tlg_byte_t BRAKE_LEVEL,
  output logic TRAILER_BRAKE,
  output logic MUD_MODE
);
  import tlg_pkg::*;
  localparam int PWR_T = `TLG_MS2TICKS(`TLG_POWERUP_MS);
  localparam int RAPID_T = `TLG_MS2TICKS(`TLG_RAPID_HALF_MS);
  localparam int SLOW_T = `TLG_MS2TICKS(`TLG_SLOW_HALF_MS);
  localparam int TOUT_T = `TLG_MS2TICKS(`TLG_DB_TIMEOUT_MS);
  localparam int COOL_T = `TLG_MS2TICKS(`TLG_DB_COOL_MS);

  // ****************************************
  // tick divider
  // ****************************************
  logic [19:0] div;
  logic tick;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div <= '0;
    end else if (div == 20'(TICK_CYCLES - 1)) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign tick = (div == 20'(TICK_CYCLES - 1));

  // ****************************************
  // register slave
  // ****************************************
  logic ack;
  logic [3:0] ctrl;
  tlg_byte_t pedal_thr;
  logic sw_mud;
  logic [31:0] status;
  logic wr_en;
  assign AVS_WAITREQUEST = ~ack;
  assign wr_en = ack && AVS_WRITE && AVS_BYTEENABLE[0];
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack <= 1'b0;
      AVS_READDATA <= '0;
    end else begin
      ack <= (AVS_READ || AVS_WRITE) && !ack;
      if (AVS_READ && !ack) begin
        unique case (AVS_ADDRESS)
          `TLG_REG_CTRL: AVS_READDATA <= {28'h0, ctrl};
          `TLG_REG_PEDAL: AVS_READDATA <= {24'h0, pedal_thr};
          `TLG_REG_STATUS: AVS_READDATA <= status;
          default: AVS_READDATA <= '0;
        endcase
      end
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= `TLG_CTRL_RST;
      pedal_thr <= `TLG_PEDAL_RST;
      sw_mud <= 1'b0;
    end else begin
      sw_mud <= 1'b0;
      if (wr_en && AVS_ADDRESS == `TLG_REG_CTRL) begin
        ctrl <= AVS_WRITEDATA[3:0];
        ctrl[`TLG_CTRL_MUD] <= 1'b0;
        sw_mud <= AVS_WRITEDATA[`TLG_CTRL_MUD];
      end
      if (wr_en && AVS_ADDRESS == `TLG_REG_PEDAL) begin
        pedal_thr <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // ****************************************
  // switch synchroniser and mud/snow mode
  // ****************************************
  logic sw_s1;
  logic sw_s2;
  logic sw_s3;
  logic sw_rise;
  logic sw_fall;
  tlg_mud_t mud_state;
  tlg_mud_t next_mud;
  logic mud_on;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_s3 <= 1'b0;
    end else begin
      sw_s1 <= MUD_SW;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
    end
  end
  assign sw_rise = sw_s2 && !sw_s3;
  assign sw_fall = !sw_s2 && sw_s3;
  always_comb begin
    next_mud = mud_state;
    unique case (mud_state)
      MUD_OFF: begin
        if (sw_rise) begin
          next_mud = MUD_HELD;
        end else if (NET_MUD_REQ || sw_mud) begin
          next_mud = MUD_ON;
        end
      end
      MUD_HELD: if (sw_fall) next_mud = MUD_ON;
      MUD_ON: if (sw_rise) next_mud = MUD_EXIT;
      MUD_EXIT: if (sw_fall) next_mud = MUD_OFF;
    endcase
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mud_state <= MUD_OFF;
    end else begin
      mud_state <= next_mud;
    end
  end
  assign mud_on = (mud_state != MUD_OFF);

  // ****************************************
  // power-up window and service brake latch
  // ****************************************
  logic [11:0] pwr_cnt;
  logic st_done;
  logic brake_seen;
  tlg_ticker #(.W(12)) u_pwr (
    .CLK(CLK), .SYS_RST(SYS_RST), .tick(tick), .clr(1'b0), .run(!st_done),
    .count(pwr_cnt)
  );
  assign st_done = (pwr_cnt >= 12'(PWR_T));
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      brake_seen <= 1'b0;
    end else if (SVC_BRAKE) begin
      brake_seen <= 1'b1;
    end
  end

  // ****************************************
  // inhibits and differential braking timeout
  // ****************************************
  logic dyno;
  logic tool;
  logic eng_ok;
  logic db_want;
  logic db_ok;
  logic db_active;
  logic timed_out;
  logic [11:0] act_cnt;
  logic [11:0] cool_cnt;
  logic offroad_slow;
  logic stab_ok;
  assign dyno = ctrl[`TLG_CTRL_DYNO];
  assign tool = ctrl[`TLG_CTRL_TOOL];
  assign eng_ok = brake_seen && !PARK_MSG && !dyno && !tool && !FAULT_INHIBIT;
  assign db_want = SPIN_LEFT ^ SPIN_RIGHT;
  assign db_ok = eng_ok && (SPEED_MPH <= `TLG_DB_MAX_MPH) && !timed_out;
  assign db_active = db_want && db_ok;
  assign offroad_slow = SKID_OFFROAD && (SPEED_MPH < `TLG_OFFROAD_MPH);
  assign stab_ok = !offroad_slow && !dyno && !FAULT_INHIBIT && !STAB_OFF;
  tlg_ticker #(.W(12)) u_act (
    .CLK(CLK), .SYS_RST(SYS_RST), .tick(tick), .clr(!db_active), .run(1'b1),
    .count(act_cnt)
  );
  tlg_ticker #(.W(12)) u_cool (
    .CLK(CLK), .SYS_RST(SYS_RST), .tick(tick), .clr(!timed_out), .run(1'b1),
    .count(cool_cnt)
  );
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      timed_out <= 1'b0;
    end else if (!timed_out && act_cnt >= 12'(TOUT_T)) begin
      timed_out <= 1'b1;
    end else if (timed_out && cool_cnt >= 12'(COOL_T)) begin
      timed_out <= 1'b0;
    end
  end

  // ****************************************
  // brake, torque and slip outputs
  // ****************************************
  logic yaw;
  logic yaw_armed;
  tlg_corner_t next_wheel;
  tlg_byte_t next_slip;
  always_comb begin
    next_slip = `TLG_SLIP_BASE;
    if (eng_ok && CORNERING) begin
      next_slip = `TLG_SLIP_LOW;
    end else if (eng_ok && PEDAL_POS > pedal_thr) begin
      next_slip = `TLG_SLIP_HIGH;
    end
  end
  assign yaw = (YAW_OVERSTEER || YAW_UNDERSTEER) && stab_ok;
  always_comb begin
    next_wheel = '0;
    if (ROLL_EVENT && stab_ok) begin
      next_wheel = '1;
    end else if (yaw && yaw_armed) begin
      if (YAW_OVERSTEER) begin
        next_wheel[TURN_LEFT ? `TLG_W_FR : `TLG_W_FL] = 1'b1;
      end else begin
        next_wheel[TURN_LEFT ? `TLG_W_RL : `TLG_W_RR] = 1'b1;
      end
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      yaw_armed <= 1'b0;
      THROTTLE_CUT <= 1'b0;
      WHEEL_BRAKE <= '0;
      BRAKE_LEVEL <= '0;
      TRAILER_BRAKE <= 1'b0;
    end else begin
      yaw_armed <= yaw;
      THROTTLE_CUT <= (ROLL_EVENT && stab_ok) || yaw;
      WHEEL_BRAKE <= next_wheel;
      BRAKE_LEVEL <= (ROLL_EVENT && stab_ok) ? ROLL_RISK : '0;
      TRAILER_BRAKE <= yaw && yaw_armed && ctrl[`TLG_CTRL_TRAILER];
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DB_BRAKE_L <= 1'b0;
      DB_BRAKE_R <= 1'b0;
      ETL_REQ <= 1'b0;
      TORQUE_UP_REQ <= 1'b0;
      SLIP_TARGET <= `TLG_SLIP_BASE;
      MUD_MODE <= 1'b0;
    end else begin
      DB_BRAKE_L <= db_active && SPIN_LEFT;
      DB_BRAKE_R <= db_active && SPIN_RIGHT;
      ETL_REQ <= eng_ok && (SPIN_LEFT || SPIN_RIGHT);
      TORQUE_UP_REQ <= eng_ok && DRAG_SLIP;
      SLIP_TARGET <= next_slip;
      MUD_MODE <= mud_on;
    end
  end

  // ****************************************
  // lamp
  // ****************************************
  logic [3:0] rapid_cnt;
  logic [5:0] slow_cnt;
  logic intervening;
  logic disabled;
  logic next_lamp;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rapid_cnt <= '0;
      slow_cnt <= '0;
    end else if (tick) begin
      rapid_cnt <= (rapid_cnt == 4'(2 * RAPID_T - 1)) ? '0 : rapid_cnt + 1'b1;
      slow_cnt <= (slow_cnt == 6'(2 * SLOW_T - 1)) ? '0 : slow_cnt + 1'b1;
    end
  end
  assign intervening = TRAC_EVENT || db_active || THROTTLE_CUT;
  assign disabled = FAULT_ANY || FAULT_INHIBIT || dyno || tool || STAB_OFF || offroad_slow;
  always_comb begin
    if (!st_done) begin
      next_lamp = 1'b1;
    end else if (intervening) begin
      next_lamp = (rapid_cnt < 4'(RAPID_T));
    end else if (mud_on) begin
      next_lamp = (slow_cnt < 6'(SLOW_T));
    end else begin
      next_lamp = disabled;
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LAMP <= 1'b0;
    end else begin
      LAMP <= next_lamp;
    end
  end
  assign status = {26'h0, disabled, st_done, db_active, mud_on, timed_out, brake_seen};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence sw_press_s;
    mud_state == MUD_OFF && MUD_SW ##1 MUD_SW [*2];
  endsequence
  lamp_powerup_a: assert property (!st_done |=> LAMP)
    else $error("lamp dark in power-up window");
  lamp_steady_a: assert property (st_done && disabled && !intervening && !mud_on |=> LAMP)
    else $error("lamp not steady while disabled");
  db_speed_a: assert property (DB_BRAKE_L || DB_BRAKE_R |-> $past(SPEED_MPH) <= `TLG_DB_MAX_MPH)
    else $error("braking above speed limit");
  first_brake_a: assert property (!brake_seen |=> !DB_BRAKE_L && !ETL_REQ && !DB_BRAKE_R)
    else $error("control before first service brake");
  park_inhibit_a: assert property (PARK_MSG |=> !ETL_REQ && !DB_BRAKE_L && !DB_BRAKE_R)
    else $error("control while parked");
  dyno_inhibit_a: assert property (dyno || tool |=> !ETL_REQ && !TORQUE_UP_REQ)
    else $error("engine control in dyno or tool inhibit");
  db_timeout_a: assert property (timed_out |=> !DB_BRAKE_L && !DB_BRAKE_R)
    else $error("braking during cool-off");
  mud_enter_a: assert property (sw_press_s |-> ##[1:2] mud_on)
    else $error("switch press did not enter mud mode");
  roll_brake_a: assert property (ROLL_EVENT && stab_ok |=>
    WHEEL_BRAKE == 4'hF && BRAKE_LEVEL == $past(ROLL_RISK) && THROTTLE_CUT)
    else $error("rollover response wrong");
  yaw_order_a: assert property ($rose(yaw) |=> WHEEL_BRAKE == 4'h0 || ROLL_EVENT)
    else $error("yaw brake before throttle cut");
  slip_raise_a: assert property (eng_ok && !CORNERING && PEDAL_POS > pedal_thr
    |=> SLIP_TARGET == `TLG_SLIP_HIGH)
    else $error("slip target not raised");
endmodule
`default_nettype wire

// File: verification/tlg_far_end.sv
// tlg_far_end.sv: dash switch and network mud request of the far side
// assumes the bench clock; press is the operator holding the switch
`timescale 1ns/1ns
`default_nettype none
module tlg_far_end (
  input wire logic clk,
  input wire logic press,
  input wire logic net_push,
  output logic mud_sw,
  output logic net_mud_req
);
  // ****************************************
  // switch pin and network message
  // ****************************************
  logic push_d;
  initial begin
    mud_sw = 1'b0;
    net_mud_req = 1'b0;
    push_d = 1'b0;
  end
  // pin moves off the clock edge, as an async switch would
  always @(negedge clk) begin
    mud_sw <= press;
  end
  // one-cycle network request per push
  always @(posedge clk) begin
    push_d <= net_push;
    net_mud_req <= net_push & !push_d;
  end
endmodule
`default_nettype wire

// File: verification/tb_traction_lamp_and_brake_gating.sv
// tb_traction_lamp_and_brake_gating.sv: self-checking bench of tlg_gating
// assumes tlg_cfg.svh, tlg_pkg and the far-side model tlg_far_end
`timescale 1ns/1ns
`default_nettype none
`include "tlg_cfg.svh"
module tb_traction_lamp_and_brake_gating;
  import tlg_pkg::*;
  localparam int TC = 4;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic AVS_READ = 0, AVS_WRITE = 0, SPIN_LEFT = 0, SPIN_RIGHT = 0, SVC_BRAKE = 0;
  logic PARK_MSG = 0, FAULT_ANY = 0, FAULT_INHIBIT = 0, STAB_OFF = 0, SKID_OFFROAD = 0;
  logic TRAC_EVENT = 0, CORNERING = 0, ROLL_EVENT = 0, YAW_OVERSTEER = 0;
  logic YAW_UNDERSTEER = 0, TURN_LEFT = 0, DRAG_SLIP = 0, press = 0, net_push = 0;
  tlg_byte_t SPEED_MPH = 8'h0A;
  tlg_byte_t PEDAL_POS = 8'hC0;
  tlg_byte_t ROLL_RISK = 8'h00;
  wire logic [31:0] AVS_READDATA;
  wire logic AVS_WAITREQUEST, MUD_SW, NET_MUD_REQ, LAMP, DB_BRAKE_L, DB_BRAKE_R, ETL_REQ;
  wire logic TORQUE_UP_REQ, THROTTLE_CUT, TRAILER_BRAKE, MUD_MODE;
  wire tlg_byte_t SLIP_TARGET, BRAKE_LEVEL;
  wire tlg_corner_t WHEEL_BRAKE;
  logic [31:0] d;
  tlg_byte_t lvl;
  int n, err_total = 0, checked = 0;

  tlg_gating #(.TICK_CYCLES(TC)) dut (.CLK(CLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MUD_SW(MUD_SW),
    .NET_MUD_REQ(NET_MUD_REQ), .SPEED_MPH(SPEED_MPH), .SPIN_LEFT(SPIN_LEFT),
    .SPIN_RIGHT(SPIN_RIGHT), .SVC_BRAKE(SVC_BRAKE), .PARK_MSG(PARK_MSG),
    .FAULT_ANY(FAULT_ANY), .FAULT_INHIBIT(FAULT_INHIBIT), .STAB_OFF(STAB_OFF),
    .SKID_OFFROAD(SKID_OFFROAD), .TRAC_EVENT(TRAC_EVENT), .PEDAL_POS(PEDAL_POS),
    .CORNERING(CORNERING), .ROLL_EVENT(ROLL_EVENT), .ROLL_RISK(ROLL_RISK),
    .YAW_OVERSTEER(YAW_OVERSTEER), .YAW_UNDERSTEER(YAW_UNDERSTEER),
    .TURN_LEFT(TURN_LEFT), .DRAG_SLIP(DRAG_SLIP), .LAMP(LAMP), .DB_BRAKE_L(DB_BRAKE_L),
    .DB_BRAKE_R(DB_BRAKE_R), .ETL_REQ(ETL_REQ), .TORQUE_UP_REQ(TORQUE_UP_REQ),
    .SLIP_TARGET(SLIP_TARGET), .THROTTLE_CUT(THROTTLE_CUT), .WHEEL_BRAKE(WHEEL_BRAKE),
    .BRAKE_LEVEL(BRAKE_LEVEL), .TRAILER_BRAKE(TRAILER_BRAKE), .MUD_MODE(MUD_MODE));

  tlg_far_end far (.clk(CLK), .press(press), .net_push(net_push), .mud_sw(MUD_SW),
    .net_mud_req(NET_MUD_REQ));

  always #50 CLK = ~CLK;

  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge CLK);
  endtask
  task look;
    @(negedge CLK);
  endtask
  task req(input logic w, input logic [3:0] a, input logic [31:0] wd,
      input logic [3:0] be, output logic [31:0] q);
    int k;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
    if (AVS_WAITREQUEST !== 1'b0) err_total++;
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task half(output int c);
    logic l;
    @(negedge CLK);
    // skip two changes so the count starts on a true phase boundary
    for (int j = 0; j < 2; j++) begin
      l = LAMP;
      for (int k = 0; k < 400 && LAMP === l; k++) @(negedge CLK);
    end
    l = LAMP;
    c = 0;
    while (LAMP === l && c < 400) begin
      @(negedge CLK);
      c++;
    end
  endtask
  task sw_cycle;
    @(posedge CLK) press <= 1'b1;
    cyc(10);
    @(posedge CLK) press <= 1'b0;
    cyc(10);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge CLK);
    err_total++;
    complete_run();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    SPIN_LEFT = 1'b1;
    cyc(9);
    look;
    chk("rst slip", SLIP_TARGET, `TLG_SLIP_BASE);
    chk("rst wait", AVS_WAITREQUEST, 1);
    @(posedge CLK) SYS_RST <= 1'b0;
    req(0, `TLG_REG_CTRL, 0, 4'hF, d);
    chk("ctrl rst", d, `TLG_CTRL_RST);
    req(1, `TLG_REG_PEDAL, 32'hFF, 4'hE, d);
    req(0, `TLG_REG_PEDAL, 0, 4'hF, d);
    chk("pedal rst", d, `TLG_PEDAL_RST);
    req(0, 4'hC, 0, 4'hF, d);
    chk("unmapped", d, 0);
    cyc(80);
    look;
    chk("lamp pwrup", LAMP, 1);
    chk("db early", DB_BRAKE_L, 0);
    chk("etl early", ETL_REQ, 0);
    chk("slip early", SLIP_TARGET, `TLG_SLIP_BASE);
    cyc(130);
    look;
    chk("lamp off", LAMP, 0);
    @(posedge CLK) SVC_BRAKE <= 1'b1;
    @(posedge CLK) SVC_BRAKE <= 1'b0;
    cyc(2);
    look;
    chk("db left", {DB_BRAKE_L, DB_BRAKE_R}, 2'b10);
    chk("slip high", SLIP_TARGET, `TLG_SLIP_HIGH);
    for (int s = 25; s < 27; s++) begin
      @(posedge CLK) SPEED_MPH <= 8'(s);
      cyc(2);
      look;
      chk("db speed", DB_BRAKE_L, s <= 25);
      chk("etl speed", ETL_REQ, 1);
    end
    @(posedge CLK) SPEED_MPH <= 8'h0A;
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      PARK_MSG <= (i == 0);
      FAULT_INHIBIT <= (i == 1);
      if (i > 1) req(1, `TLG_REG_CTRL, 32'h8 | (1 << (i - 2)), 4'h1, d);
      cyc(2);
      look;
      chk("db inh", DB_BRAKE_L, 0);
      chk("etl inh", ETL_REQ, 0);
      chk("slip inh", SLIP_TARGET, `TLG_SLIP_BASE);
      req(1, `TLG_REG_CTRL, 32'h8, 4'h1, d);
    end
    @(posedge CLK) PARK_MSG <= 1'b0;
    FAULT_INHIBIT <= 1'b0;
    req(1, `TLG_REG_PEDAL, 32'hD0, 4'h1, d);
    for (int p = 0; p < 3; p++) begin
      @(posedge CLK) PEDAL_POS <= (p == 2) ? 8'h00 : 8'(8'hD0 + p);
      CORNERING <= (p == 2);
      cyc(2);
      look;
      chk("slip", SLIP_TARGET, p == 0 ? `TLG_SLIP_BASE : p == 1 ? `TLG_SLIP_HIGH :
        `TLG_SLIP_LOW);
    end
    @(posedge CLK) CORNERING <= 1'b0;
    STAB_OFF <= 1'b1;
    SPIN_LEFT <= 1'b0;
    cyc(2);
    look;
    chk("lamp dis", LAMP, 1);
    @(posedge CLK) TRAC_EVENT <= 1'b1;
    half(n);
    chk("rapid", n, `TLG_RAPID_HALF_MS / `TLG_TICK_MS * TC);
    @(posedge CLK) press <= 1'b1;
    cyc(10);
    look;
    chk("mud on", MUD_MODE, 1);
    @(posedge CLK) press <= 1'b0;
    half(n);
    chk("rapid mud", n, `TLG_RAPID_HALF_MS / `TLG_TICK_MS * TC);
    @(posedge CLK) TRAC_EVENT <= 1'b0;
    half(n);
    chk("slow", n, `TLG_SLOW_HALF_MS / `TLG_TICK_MS * TC);
    req(0, `TLG_REG_STATUS, 0, 4'hF, d);
    chk("st mud", d[`TLG_ST_MUD], 1);
    @(posedge CLK) STAB_OFF <= 1'b0;
    sw_cycle();
    look;
    chk("mud off", MUD_MODE, 0);
    @(posedge CLK) net_push <= 1'b1;
    @(posedge CLK) net_push <= 1'b0;
    cyc(4);
    look;
    chk("mud net", MUD_MODE, 1);
    sw_cycle();
    req(1, `TLG_REG_CTRL, 32'hC, 4'h1, d);
    cyc(3);
    look;
    chk("mud reg", MUD_MODE, 1);
    sw_cycle();
    for (int s = 10; s < 26; s += 15) begin
      @(posedge CLK) SKID_OFFROAD <= 1'b1;
      SPEED_MPH <= 8'(s);
      cyc(2);
      look;
      chk("offroad", LAMP, s < 25);
    end
    @(posedge CLK) SKID_OFFROAD <= 1'b0;
    SPEED_MPH <= 8'h0A;
    for (int k = 0; k < 4; k++) begin
      @(posedge CLK) YAW_OVERSTEER <= k[0];
      YAW_UNDERSTEER <= !k[0];
      TURN_LEFT <= k[1];
      cyc(1);
      look;
      chk("cut first", {THROTTLE_CUT, WHEEL_BRAKE}, 5'h10);
      look;
      chk("yaw wheel", WHEEL_BRAKE, 4'h1 << (k[0] ? k[1] : 2 + !k[1]));
      chk("trailer", TRAILER_BRAKE, 1);
      @(posedge CLK) YAW_OVERSTEER <= 1'b0;
      YAW_UNDERSTEER <= 1'b0;
      cyc(3);
    end
    @(posedge CLK) ROLL_EVENT <= 1'b1;
    ROLL_RISK <= 8'h40;
    cyc(3);
    look;
    chk("roll", {THROTTLE_CUT, WHEEL_BRAKE}, 5'h1F);
    lvl = BRAKE_LEVEL;
    @(posedge CLK) ROLL_RISK <= 8'h80;
    cyc(3);
    look;
    chk("roll scale", BRAKE_LEVEL > lvl, 1);
    @(posedge CLK) ROLL_EVENT <= 1'b0;
    DRAG_SLIP <= 1'b1;
    cyc(2);
    look;
    chk("drag", TORQUE_UP_REQ, 1);
    req(1, `TLG_REG_CTRL, 32'hA, 4'h1, d);
    cyc(2);
    look;
    chk("drag dyno", TORQUE_UP_REQ, 0);
    req(1, `TLG_REG_CTRL, 32'h8, 4'h1, d);
    @(posedge CLK) DRAG_SLIP <= 1'b0;
    SPIN_LEFT <= 1'b0;
    cyc(3);
    @(posedge CLK) SPIN_LEFT <= 1'b1;
    cyc(14300);
    look;
    chk("db long", DB_BRAKE_L, 1);
    cyc(200);
    look;
    chk("db tout", DB_BRAKE_L, 0);
    req(0, `TLG_REG_STATUS, 0, 4'hF, d);
    chk("st tout", d[`TLG_ST_TIMEOUT], 1);
    @(posedge CLK) SPIN_LEFT <= 1'b0;
    cyc(9000);
    @(posedge CLK) SPIN_LEFT <= 1'b1;
    cyc(2);
    look;
    chk("cool", DB_BRAKE_L, 0);
    cyc(700);
    look;
    chk("cool end", DB_BRAKE_L, 1);
    @(posedge CLK) FAULT_ANY <= 1'b1;
    SYS_RST <= 1'b1;
    cyc(2);
    @(posedge CLK) SYS_RST <= 1'b0;
    cyc(230);
    look;
    chk("lamp fault", LAMP, 1);
    req(0, `TLG_REG_STATUS, 0, 4'hF, d);
    chk("st clr", d[`TLG_ST_TIMEOUT], 0);
    complete_run();
  end
endmodule
`default_nettype wire
